/* design/trim_select.sv */
`timescale 1ns/1ps
module trim_select
(
  input  wire logic    mclk,
  input  wire logic    sys_rst,
  trim_select_if.sel   tsel
);
  import tx_trim_pkg::*;

  typedef struct packed
  {
    logic [3:0] trim;
  } sel_state_t;

  sel_state_t stateR;
  sel_state_t stateNxt;

  always_comb
  begin
    stateNxt = stateR;
    // [R10] Trim source select
    if (tsel.manualSel)
      stateNxt.trim = tsel.manualTrim;
    else
      stateNxt.trim = tsel.calTrim;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      stateR <= '0;
    else
      stateR <= stateNxt;
  end

  assign tsel.trimOut = stateR.trim;
endmodule

/* design/trim_select_if.sv */
`timescale 1ns/1ps
interface trim_select_if;
  logic       manualSel;
  logic [3:0] manualTrim;
  logic [3:0] calTrim;
  logic [3:0] trimOut;
  modport ctrl (output manualSel, output manualTrim, output calTrim,
                input trimOut);
  modport sel  (input manualSel, input manualTrim, input calTrim,
                output trimOut);
endinterface

/* design/tx_length_trim_regs.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// What this block does
// [R1] Low five count bits at 1Eh[7:3]
// [R2] Software keeps byte count at most 8191
// [R3] 1Eh[2:0] is split-byte bit count
// [R4] Split anticollision frame sent without parity
// [R5] Split bits, anticollision, idle card, wake command: parity irq
// [R6] Peer bit-rate result in 1Fh[7:4]
// [R7] Converter result readable at 20h
// [R8] Result registers cleared at reset, defaults
// [R9] Writable registers load defaults on reset, command
// [R10] Trim bit 7 selects manual or calibrated
// [R11] Manual bits drive both switch pin groups
// [R12] 22h is target phase, default 80h
// [R13] High eight count bits at 1Dh
// [R14] Count concatenated, sampled at transmit start
module tx_length_trim_regs
(
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  input  wire logic [7:0]                     regAddr,
  input  wire logic [7:0]                     regWrData,
  input  wire logic                           regWrite,
  input  wire logic                           regRead,
  output logic      [7:0]                     regRdData,
  input  wire logic                           setDefaults,
  input  wire logic                           txStart,
  input  wire logic                           anticollMode,
  input  wire logic                           cardIdle,
  input  wire logic                           wakeCmd,
  input  wire logic                           rateValid,
  input  wire logic [3:0]                     rateResult,
  input  wire logic                           convValid,
  input  wire logic [7:0]                     convResult,
  input  wire logic [tx_trim_pkg::TrimWidth-1:0] calTrim,
  output logic [tx_trim_pkg::TxCountWidth-1:0]   txByteCount,
  output logic      [2:0]                     txSplitBits,
  output logic                                txNoParity,
  output logic                                parityIrq,
  output logic      [7:0]                     targetPhase,
  output logic [tx_trim_pkg::TrimWidth-1:0]   tuning_switch_pins_first,
  output logic [tx_trim_pkg::TrimWidth-1:0]   tuning_switch_pins_second
);
  import tx_trim_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed
  {
    logic [7:0]              txHigh;
    logic [7:0]              txLow;
    logic [7:0]              peerRate;
    logic [7:0]              conv;
    logic [7:0]              trimCtl;
    logic [7:0]              phase;
    logic [7:0]              rdData;
    logic [TxCountWidth-1:0] count;
    logic [2:0]              split;
    logic                    noPar;
    logic                    parIrq;
  } regs_t;

  regs_t stateR;
  regs_t stateNxt;

  trim_select_if tsIf ();

  function automatic logic [7:0] readMux(input regs_t s,
                                         input logic [7:0] a);
    begin
      case (a)
        TxCountHighOff: readMux = s.txHigh;
        TxCountLowOff:  readMux = s.txLow;
        PeerRateOff:    readMux = s.peerRate;
        ConverterOff:   readMux = s.conv;
        TrimControlOff: readMux = s.trimCtl;
        TargetPhaseOff: readMux = s.phase;
        // Unmapped offsets read as zero
        default:        readMux = 8'h00;
      endcase
    end
  endfunction

  always_comb
  begin
    stateNxt        = stateR;
    stateNxt.parIrq = 1'b0;
    stateNxt.rdData = 8'h00;

    // ****************************************
    // Register writes
    // ****************************************
    if (regWrite)
    begin
      case (regAddr)
        // [R13] High count byte
        TxCountHighOff: stateNxt.txHigh  = regWrData;
        // [R1] Low count bits and split field
        TxCountLowOff:  stateNxt.txLow   = regWrData;
        // [R10] Trim source and manual value
        TrimControlOff: stateNxt.trimCtl = {regWrData[7:3], 3'h0};
        // [R12] Target phase
        TargetPhaseOff: stateNxt.phase   = regWrData;
        default:        ;
      endcase
    end

    // ****************************************
    // Result capture
    // ****************************************
    // [R6] Rate result in upper nibble
    if (rateValid)
      stateNxt.peerRate = {rateResult, 4'h0};
    // [R7] Last conversion result
    if (convValid)
      stateNxt.conv = convResult;

    // ****************************************
    // Transmit sampling
    // ****************************************
    // [R14] Count latched at transmit start
    if (txStart)
    begin
      stateNxt.count = {stateR.txHigh, stateR.txLow[TxLowMsb:TxLowLsb]};
      // [R3] Split-byte bit count
      stateNxt.split = stateR.txLow[SplitMsb:SplitLsb];
      // [R4] No parity on split anticollision frame
      stateNxt.noPar = anticollMode &&
                       (stateR.txLow[SplitMsb:SplitLsb] != NoSplit);
    end

    // [R5] Wake command with split bits flags parity
    if (wakeCmd && anticollMode && cardIdle &&
        (stateR.txLow[SplitMsb:SplitLsb] != NoSplit))
      stateNxt.parIrq = 1'b1;

    // ****************************************
    // Restore defaults wins over register writes and result capture
    // ****************************************
    if (setDefaults)
    begin
      // [R9] Writable defaults
      stateNxt.txHigh  = TxCountHighRst;
      stateNxt.txLow   = TxCountLowRst;
      stateNxt.trimCtl = TrimControlRst;
      stateNxt.phase   = TargetPhaseRst;
      // [R8] Results cleared
      stateNxt.peerRate = ResultRst;
      stateNxt.conv     = ResultRst;
    end

    // Read data reflects state before this cycle's write
    if (regRead)
      stateNxt.rdData = readMux(stateR, regAddr);
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stateR         <= '0;
      stateR.txHigh  <= TxCountHighRst;
      stateR.txLow   <= TxCountLowRst;
      stateR.trimCtl <= TrimControlRst;
      stateR.phase   <= TargetPhaseRst;
      stateR.peerRate <= ResultRst;
      stateR.conv    <= ResultRst;
    end
    else
      stateR <= stateNxt;
  end

  // ****************************************
  // Trim switch source
  // ****************************************
  assign tsIf.manualSel  = stateR.trimCtl[TrimSelBit];
  assign tsIf.manualTrim = stateR.trimCtl[TrimManMsb:TrimManLsb];
  assign tsIf.calTrim    = calTrim;

  trim_select uTrimSel
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tsel    (tsIf.sel)
  );

  // [R11] Same trim on both pin groups
  assign tuning_switch_pins_first  = tsIf.trimOut;
  assign tuning_switch_pins_second = tsIf.trimOut;

  assign regRdData   = stateR.rdData;
  assign txByteCount = stateR.count;
  assign txSplitBits = stateR.split;
  assign txNoParity  = stateR.noPar;
  assign parityIrq   = stateR.parIrq;
  assign targetPhase = stateR.phase;
endmodule

/* design/tx_trim_pkg.sv */
package tx_trim_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] TxCountHighOff  = 8'h1D;
  localparam logic [7:0] TxCountLowOff   = 8'h1E;
  localparam logic [7:0] PeerRateOff     = 8'h1F;
  localparam logic [7:0] ConverterOff    = 8'h20;
  localparam logic [7:0] TrimControlOff  = 8'h21;
  localparam logic [7:0] TargetPhaseOff  = 8'h22;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] TxCountHighRst  = 8'h00;
  localparam logic [7:0] TxCountLowRst   = 8'h00;
  localparam logic [7:0] TrimControlRst  = 8'h00;
  localparam logic [7:0] TargetPhaseRst  = 8'h80;
  localparam logic [7:0] ResultRst       = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TxLowMsb      = 7;
  localparam int TxLowLsb      = 3;
  localparam int SplitMsb      = 2;
  localparam int SplitLsb      = 0;
  localparam int RateMsb       = 7;
  localparam int RateLsb       = 4;
  localparam int TrimSelBit    = 7;
  localparam int TrimManMsb    = 6;
  localparam int TrimManLsb    = 3;
  localparam int TxCountWidth  = 13;
  localparam int TrimWidth     = 4;

  localparam logic [2:0] NoSplit = 3'h0;

endpackage

/* verification/tx_length_trim_regs_bench.sv */
`timescale 1ns/1ps
module tx_length_trim_regs_bench;
  import tx_trim_pkg::*;
  logic        mclk, sys_rst, regWrite, regRead, setDefaults, txStart;
  logic        anticollMode, cardIdle, wakeCmd, rateValid, convValid;
  logic        txNoParity, parityIrq;
  logic [7:0]  regAddr, regWrData, regRdData, convResult, targetPhase;
  logic [3:0]  rateResult, calTrim;
  logic [3:0]  tuning_switch_pins_first, tuning_switch_pins_second;
  logic [12:0] txByteCount;
  logic [2:0]  txSplitBits;
  int          mismatches = 0;
  int          checksDone = 0;

  tx_length_trim_regs i_tx_length_trim_regs (.*);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [12:0] got, input logic [12:0] want);
    checksDone++;
    if (got !== want)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // Pulses last exactly one cycle; settle and rd drop them after the next edge
  task automatic drop;
    {txStart, wakeCmd, setDefaults, rateValid, convValid} <= '0;
  endtask
  task automatic settle;
    @(posedge mclk);
    drop;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge mclk);
    drop;
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, want);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic check_defaults;
    for (int a = 8'h1D; a <= 8'h23; a++)
      rd(a[7:0], (a == 8'h22) ? TargetPhaseRst : ResultRst);
  endtask
  task automatic rw_fields;
    wr(TxCountHighOff, 8'hFF);
    wr(TxCountLowOff, 8'hFD);
    wr(PeerRateOff, 8'h55);
    wr(TargetPhaseOff, 8'h5A);
    wr(TrimControlOff, 8'hFF);
    rd(TxCountLowOff, 8'hFD);
    rd(TxCountHighOff, 8'hFF);
    rd(PeerRateOff, 8'h00);
    rd(TrimControlOff, 8'hF8);
    rd(TargetPhaseOff, 8'h5A);
    chk(targetPhase, 8'h5A);
    chk(tuning_switch_pins_second, 4'hF);
  endtask
  task automatic tx_frames;
    @(posedge mclk) {anticollMode, txStart} <= 2'h3;
    settle;
    chk(txByteCount, 13'h1FFF);
    chk(txSplitBits, 3'h5);
    chk(txNoParity, 1'b1);
    wr(TxCountLowOff, 8'h10);
    @(posedge mclk) txStart <= 1'b1;
    settle;
    chk(txByteCount, 13'h1FE2);
    chk(txNoParity, 1'b0);
    wr(TxCountHighOff, 8'h01);
    chk(txByteCount, 13'h1FE2);
  endtask
  task automatic parity_irq;
    wr(TxCountLowOff, 8'h13);
    @(posedge mclk) {cardIdle, wakeCmd} <= 2'h3;
    settle;
    chk(parityIrq, 1'b1);
    @(posedge mclk) {cardIdle, wakeCmd} <= 2'h1;
    settle;
    chk(parityIrq, 1'b0);
  endtask
  task automatic trim_source;
    wr(TrimControlOff, 8'hC8);
    @(posedge mclk) calTrim <= 4'h6;
    settle;
    chk(tuning_switch_pins_first, 4'h9);
    wr(TrimControlOff, 8'h48);
    settle;
    chk(tuning_switch_pins_first, 4'h6);
  endtask
  task automatic results_and_defaults;
    @(posedge mclk) {rateValid, rateResult, convValid, convResult}
      <= {1'b1, 4'hA, 1'b1, 8'h5C};
    settle;
    rd(PeerRateOff, 8'hA0);
    rd(ConverterOff, 8'h5C);
    @(posedge mclk) setDefaults <= 1'b1;
    rd(PeerRateOff, 8'h00);
    check_defaults;
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    {regWrite, regRead, setDefaults, txStart, wakeCmd} = '0;
    {anticollMode, cardIdle, rateValid, convValid} = '0;
    {regAddr, regWrData, convResult, rateResult, calTrim} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    check_defaults;
    rw_fields;
    tx_frames;
    parity_irq;
    trim_source;
    results_and_defaults;
    wrap_up;
  end
  // Under a hundred cycles suffice; this cuts a hang short
  initial
  begin
    #20us;
    mismatches++;
    wrap_up;
  end
endmodule

bind tx_length_trim_regs tx_trim_checker i_tx_trim_checker (.*);

/* verification/tx_trim_checker_assertions.sv */
`timescale 1ns/1ps
module tx_trim_checker
(
  input logic        mclk,
  input logic        sys_rst,
  input logic [7:0]  regAddr,
  input logic        regRead,
  input logic [7:0]  regRdData,
  input logic        setDefaults,
  input logic        txStart,
  input logic        anticollMode,
  input logic        cardIdle,
  input logic        wakeCmd,
  input logic [3:0]  calTrim,
  input logic [12:0] txByteCount,
  input logic [2:0]  txSplitBits,
  input logic        txNoParity,
  input logic        parityIrq,
  input logic [7:0]  targetPhase,
  input logic [3:0]  tuning_switch_pins_first,
  input logic [3:0]  tuning_switch_pins_second
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ****************
  // Port relations
  // ****************
  a_read_idle_zero:
    assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("stray read data");
  a_phase_default:
    assert property ($past(setDefaults) |-> targetPhase == 8'h80)
    else $error("target phase default lost");
  a_irq_needs_wake:
    assert property (parityIrq |-> $past(wakeCmd & anticollMode & cardIdle))
    else $error("parity irq without cause");
  a_pins_match:
    assert property (tuning_switch_pins_first == tuning_switch_pins_second)
    else $error("switch groups differ");
  a_count_holds:
    assert property (!$past(txStart | setDefaults) |-> $stable(txByteCount))
    else $error("count moved without transmit start");
  a_noparity_split:
    assert property ($past(txStart) |->
      txNoParity == ($past(anticollMode) && txSplitBits != 3'h0))
    else $error("parity suppression wrong");
  // Defaults pick the calibrated source, so pins follow it
  a_trim_calib:
    assert property ($past(setDefaults, 2) |->
      tuning_switch_pins_first == $past(calTrim))
    else $error("pins not from calibration");
  a_result_cleared:
    assert property ($past(setDefaults, 2) && $past(regRead) &&
      $past(regAddr) == 8'h1F |-> regRdData == 8'h00)
    else $error("rate result not cleared");
  c_irq: cover property (parityIrq);
  c_noparity: cover property ($rose(txNoParity));
  c_manual: cover property (tuning_switch_pins_first == 4'h9);
endmodule
